// *** hw/isp_pkg.sv ***
// Shared constants and types for the serial in-system programming port.
package isp_pkg;
  // First instruction byte of each supported operation.
  localparam logic [7:0] OP_SPECIAL = 8'hAC;
  localparam logic [7:0] OP_POLL = 8'hF0;
  localparam logic [7:0] OP_LD_EXT = 8'h4D;
  localparam logic [7:0] OP_LD_PG_HI = 8'h48;
  localparam logic [7:0] OP_LD_PG_LO = 8'h40;
  localparam logic [7:0] OP_LD_EE_PG = 8'hC1;
  localparam logic [7:0] OP_RD_PG_HI = 8'h28;
  localparam logic [7:0] OP_RD_PG_LO = 8'h20;
  localparam logic [7:0] OP_RD_EE = 8'hA0;
  localparam logic [7:0] OP_RD_LOCK_HF = 8'h58;
  localparam logic [7:0] OP_RD_SIG = 8'h30;
  localparam logic [7:0] OP_RD_FUSE = 8'h50;
  localparam logic [7:0] OP_RD_CAL = 8'h38;
  localparam logic [7:0] OP_WR_PG = 8'h4C;
  localparam logic [7:0] OP_WR_EE = 8'hC0;
  localparam logic [7:0] OP_WR_EE_PG = 8'hC2;
  // Second byte qualifiers.
  localparam logic [7:0] SUB_ENABLE = 8'h53;
  localparam logic [7:0] SUB_ERASE = 8'h80;
  localparam logic [7:0] SUB_LOCK = 8'hE0;
  localparam logic [7:0] SUB_FUSE_LO = 8'hA0;
  localparam logic [7:0] SUB_FUSE_HI = 8'hA8;
  localparam logic [7:0] SUB_FUSE_EXT = 8'hA4;
  localparam logic [7:0] SUB_HIGH_SEL = 8'h08;
  localparam logic [7:0] SUB_NONE = 8'h00;
  // Value of an erased or unprogrammed byte.
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Frame geometry: four bytes, most significant bit first.
  localparam logic [4:0] LAST_BIT = 5'h1F;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [1:0] BYTE_IDX_THIRD = 2'h2;
  // Device self-timed operation lengths in nanoseconds, and the clock period.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned FLASH_PAGE_WAIT_TIME_NS = 4500000;
  localparam int unsigned EEPROM_WRITE_WAIT_TIME_NS = 3600000;
  localparam int unsigned CHIP_ERASE_WAIT_TIME_NS = 9000000;
  // Longest times round down so the device never outlasts the host's wait.
  localparam int unsigned FLASH_PAGE_WAIT_CYC = FLASH_PAGE_WAIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned EEPROM_WRITE_WAIT_CYC = EEPROM_WRITE_WAIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CHIP_ERASE_WAIT_CYC = CHIP_ERASE_WAIT_TIME_NS / CLK_PERIOD_NS;

  // One received instruction frame, byte 1 in the top bits.
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } isp_frame_s;

  // Self-timed operation in progress.
  typedef enum logic [2:0] {
    ISP_IDLE,
    ISP_FLASH_PAGE,
    ISP_EE_BYTE,
    ISP_EE_PAGE,
    ISP_ERASE,
    ISP_FUSE
  } isp_op_e;
endpackage

// *** hw/isp_serial_prog.sv ***
// Serial in-system programming port: frame receiver, decoder, memories and busy timing.
`timescale 1ns/1ps
module isp_serial_prog
  import isp_pkg::*;
#(
  parameter int FLASH_AW = 16,
  parameter int PAGE_AW = 7,
  parameter int EE_AW = 10,
  parameter int EE_PAGE_AW = 2,
  parameter int unsigned FLASH_WAIT_CYC = FLASH_PAGE_WAIT_CYC,
  parameter int unsigned EE_WAIT_CYC = EEPROM_WRITE_WAIT_CYC,
  parameter int unsigned ERASE_WAIT_CYC = CHIP_ERASE_WAIT_CYC,
  parameter logic [23:0] SIGNATURE = 24'h123456, // Arbitrary identity value.
  parameter logic [7:0] CALIBRATION = 8'h80,
  parameter logic [7:0] FUSE_LO_INIT = 8'hFF,
  parameter logic [7:0] FUSE_HI_INIT = 8'hFF,
  parameter logic [7:0] FUSE_EXT_INIT = 8'hFF
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin_reset_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output logic operation_pending_flag
);
  localparam int SW = FLASH_AW + 1;
  localparam int FLASH_WORDS = 1 << FLASH_AW;
  localparam int EE_BYTES = 1 << EE_AW;

  // Refuse geometries the sweep counter and timers cannot cover.
  // A page must be smaller than the array, or the page base field would vanish.
  if (PAGE_AW < 1 || PAGE_AW >= FLASH_AW || FLASH_AW > 24 || EE_AW > FLASH_AW ||
      EE_PAGE_AW < 1 || EE_PAGE_AW >= EE_AW || EE_AW > 12 ||
      ERASE_WAIT_CYC <= FLASH_WORDS || FLASH_WAIT_CYC <= (1 << PAGE_AW) ||
      EE_WAIT_CYC <= (1 << EE_PAGE_AW))
  begin : g_bad_params
    $error("isp_serial_prog: unsupported geometry or timing parameters");
  end

  // Word index into the flash from extended, high and low address bytes.
  function automatic logic [FLASH_AW-1:0] flash_index(input logic [7:0] e, input logic [7:0] h,
                                                      input logic [7:0] l);
    logic [23:0] full;
    full = {e, h, l};
    return full[FLASH_AW-1:0];
  endfunction

  // Byte index into the EEPROM from the two address bytes.
  function automatic logic [EE_AW-1:0] ee_index(input logic [7:0] h, input logic [7:0] l);
    logic [15:0] full;
    full = {h, l};
    return full[EE_AW-1:0];
  endfunction

  // Pin synchronisers; logic reads the second stage, plus sck_last, a third stage on sck for edge detection.
  logic rst_meta, rst_sync, sck_meta, sck_sync, sck_last, mosi_meta, mosi_sync;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_last <= 1'b0;
      mosi_meta <= 1'b0;
      mosi_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= pin_reset_n;
      rst_sync <= rst_meta;
      sck_meta <= sck;
      sck_sync <= sck_meta;
      sck_last <= sck_sync;
      mosi_meta <= mosi;
      mosi_sync <= mosi_meta;
    end
  end

  // The port only listens while the reset pin is low.
  logic prog_sel, sck_rise, sck_fall;
  assign prog_sel = !rst_sync;
  assign sck_rise = prog_sel && sck_sync && !sck_last;
  assign sck_fall = prog_sel && !sck_sync && sck_last;

  // Receive shift register and bit counter; 32 bits close a frame.
  logic [31:0] rx_sr, next_rx;
  logic [4:0] bit_cnt;
  logic frame_done, byte_done;
  isp_frame_s fr;
  assign next_rx = {rx_sr[30:0], mosi_sync};
  assign fr = next_rx;
  assign byte_done = sck_rise && (bit_cnt[2:0] == BYTE_LAST_BIT);
  assign frame_done = sck_rise && (bit_cnt == LAST_BIT);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_sr <= '0;
      bit_cnt <= '0;
    end
    else if (!prog_sel)
    begin
      // Raising the pin realigns the frame, which is how the host resyncs.
      rx_sr <= '0;
      bit_cnt <= '0;
    end
    else if (sck_rise)
    begin
      rx_sr <= next_rx;
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // Stored state: enable, extended address, fuses, lock, busy timer.
  logic enabled;
  logic [7:0] ext_addr, fuse_lo, fuse_hi, fuse_ext, lock_bits;
  isp_op_e op;
  logic [31:0] timer;
  logic [SW-1:0] sweep;
  logic [FLASH_AW-1:0] op_addr;
  logic accept;
  assign operation_pending_flag = (timer != 32'h0);
  // Work commands are dropped while disabled or busy; the host must poll.
  assign accept = frame_done && enabled && !operation_pending_flag;

  // Memories; nonvolatile contents are not touched by reset.
  logic [7:0] fl_lo [FLASH_WORDS];
  logic [7:0] fl_hi [FLASH_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [7:0] pg_lo [1 << PAGE_AW];
  logic [7:0] pg_hi [1 << PAGE_AW];
  logic [7:0] ee_buf [1 << EE_PAGE_AW];

  // Enable is set by a full frame AC 53 and lost when the pin goes high.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      enabled <= 1'b0;
    else if (!prog_sel)
      enabled <= 1'b0;
    else if (frame_done && fr.op == OP_SPECIAL && fr.b2 == SUB_ENABLE)
      enabled <= 1'b1;
  end

  // Extended address byte is retained until the next load.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ext_addr <= '0;
    else if (accept && fr.op == OP_LD_EXT)
      ext_addr <= fr.b3;
  end

  // Fuse and lock bytes; a zero bit is programmed.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fuse_lo <= FUSE_LO_INIT;
      fuse_hi <= FUSE_HI_INIT;
      fuse_ext <= FUSE_EXT_INIT;
      lock_bits <= ERASED_BYTE;
    end
    else if (accept && fr.op == OP_SPECIAL)
    begin
      case (fr.b2)
        SUB_ERASE: lock_bits <= ERASED_BYTE; // Only erase clears lock bits.
        SUB_LOCK: lock_bits <= lock_bits & fr.b4; // Lock bits can only be programmed.
        SUB_FUSE_LO: fuse_lo <= fr.b4;
        SUB_FUSE_HI: fuse_hi <= fr.b4;
        SUB_FUSE_EXT: fuse_ext <= fr.b4;
        default: lock_bits <= lock_bits;
      endcase
    end
  end

  // Page buffers; low and high bytes of a word load separately.
  always_ff @(posedge clk)
  begin
    if (accept && fr.op == OP_LD_PG_LO)
      pg_lo[fr.b3[PAGE_AW-1:0]] <= fr.b4;
    if (accept && fr.op == OP_LD_PG_HI)
      pg_hi[fr.b3[PAGE_AW-1:0]] <= fr.b4;
    if (accept && fr.op == OP_LD_EE_PG)
      ee_buf[fr.b3[EE_PAGE_AW-1:0]] <= fr.b4;
  end

  // Self-timed operation launcher and countdown.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op <= ISP_IDLE;
      timer <= '0;
      sweep <= '0;
      op_addr <= '0;
    end
    else if (accept && (fr.op == OP_WR_PG || fr.op == OP_WR_EE || fr.op == OP_WR_EE_PG ||
                        fr.op == OP_SPECIAL && fr.b2 != SUB_ENABLE))
    begin
      sweep <= '0;
      case (fr.op)
        OP_WR_PG:
        begin
          // Any word in the page selects the page.
          op <= ISP_FLASH_PAGE;
          timer <= FLASH_WAIT_CYC;
          op_addr <= flash_index(ext_addr, fr.b2, fr.b3);
        end
        OP_WR_EE:
        begin
          op <= ISP_EE_BYTE; // Erase and write in one self-timed step.
          timer <= EE_WAIT_CYC;
          op_addr <= FLASH_AW'(ee_index(fr.b2, fr.b3));
        end
        OP_WR_EE_PG:
        begin
          op <= ISP_EE_PAGE;
          timer <= EE_WAIT_CYC;
          op_addr <= FLASH_AW'(ee_index(fr.b2, fr.b3));
        end
        default:
        begin
          op <= (fr.b2 == SUB_ERASE) ? ISP_ERASE : ISP_FUSE;
          timer <= (fr.b2 == SUB_ERASE) ? ERASE_WAIT_CYC : FLASH_WAIT_CYC;
        end
      endcase
    end
    else if (timer != 32'h0)
    begin
      timer <= timer - 32'h1;
      if (sweep != {SW{1'b1}})
        sweep <= sweep + {{(SW-1){1'b0}}, 1'b1};
      if (timer == 32'h1)
        op <= ISP_IDLE;
    end
  end

  // Array writes, one word per cycle, swept within the busy time.
  logic [7:0] fr_b4_hold; // Data byte of a pending EEPROM byte write.
  logic [FLASH_AW-1:0] fl_wr_idx;
  logic [EE_AW-1:0] ee_wr_idx;
  assign fl_wr_idx = {op_addr[FLASH_AW-1:PAGE_AW], sweep[PAGE_AW-1:0]};
  assign ee_wr_idx = {op_addr[EE_AW-1:EE_PAGE_AW], sweep[EE_PAGE_AW-1:0]};
  always_ff @(posedge clk)
  begin
    if (op == ISP_ERASE && sweep < SW'(FLASH_WORDS))
    begin
      fl_lo[sweep[FLASH_AW-1:0]] <= ERASED_BYTE;
      fl_hi[sweep[FLASH_AW-1:0]] <= ERASED_BYTE;
    end
    else if (op == ISP_FLASH_PAGE && sweep < SW'(1 << PAGE_AW))
    begin
      fl_lo[fl_wr_idx] <= pg_lo[sweep[PAGE_AW-1:0]];
      fl_hi[fl_wr_idx] <= pg_hi[sweep[PAGE_AW-1:0]];
    end
  end
  always_ff @(posedge clk)
  begin
    if (op == ISP_ERASE && sweep < SW'(EE_BYTES))
      ee_mem[sweep[EE_AW-1:0]] <= ERASED_BYTE;
    else if (op == ISP_EE_PAGE && sweep < SW'(1 << EE_PAGE_AW))
      ee_mem[ee_wr_idx] <= ee_buf[sweep[EE_PAGE_AW-1:0]];
    else if (op == ISP_EE_BYTE && sweep == '0)
      ee_mem[op_addr[EE_AW-1:0]] <= fr_b4_hold;
  end

  // Data byte of an EEPROM byte write, kept for its self-timed step.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fr_b4_hold <= ERASED_BYTE;
    else if (accept && fr.op == OP_WR_EE)
      fr_b4_hold <= fr.b4;
  end

  // Bytes one to three as they stand when the third byte closes; the top byte of the
  // shift register still holds the previous frame then, so the full view cannot be used.
  isp_frame_s hd;
  assign hd = {next_rx[23:0], SUB_NONE};

  // Fourth-byte answer, chosen from the first three bytes just received.
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    case (hd.op)
      OP_POLL: rd_byte = {7'h00, operation_pending_flag};
      OP_RD_PG_HI: rd_byte = fl_hi[flash_index(ext_addr, hd.b2, hd.b3)];
      OP_RD_PG_LO: rd_byte = fl_lo[flash_index(ext_addr, hd.b2, hd.b3)];
      OP_RD_EE: rd_byte = ee_mem[ee_index(hd.b2, hd.b3)];
      OP_RD_LOCK_HF: rd_byte = (hd.b2 == SUB_HIGH_SEL) ? fuse_hi : lock_bits;
      OP_RD_FUSE: rd_byte = (hd.b2 == SUB_HIGH_SEL) ? fuse_ext : fuse_lo;
      OP_RD_SIG: rd_byte = SIGNATURE[(5'(hd.b3[1:0]) << 3) +: 8];
      OP_RD_CAL: rd_byte = CALIBRATION;
      default: rd_byte = 8'h00;
    endcase
  end

  // Output byte staged on each byte boundary: echo, or read data for byte four.
  logic [7:0] out_pend, out_sr;
  logic load_pend;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_pend <= '0;
      load_pend <= 1'b0;
    end
    else if (!prog_sel)
      load_pend <= 1'b0;
    else if (byte_done)
    begin
      // The byte just received echoes next, so AC 53 shows 53 in byte three.
      out_pend <= (bit_cnt[4:3] == BYTE_IDX_THIRD) ? rd_byte : next_rx[7:0];
      load_pend <= 1'b1;
    end
    else if (sck_fall)
      load_pend <= 1'b0;
  end

  // Serial output changes only on falling clock edges, MSB first.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_sr <= '0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      miso_oe <= prog_sel;
      if (sck_fall && load_pend)
      begin
        miso <= out_pend[7];
        out_sr <= {out_pend[6:0], 1'b0};
      end
      else if (sck_fall)
      begin
        miso <= out_sr[7];
        out_sr <= {out_sr[6:0], 1'b0};
      end
    end
  end

  a_pin_high_oe: assert property (@(posedge clk) disable iff (!reset_n)
    rst_sync |=> !miso_oe) else $error("output enabled while reset pin high");
  a_pin_high_enable: assert property (@(posedge clk) disable iff (!reset_n)
    rst_sync |=> !enabled) else $error("enable kept while reset pin high");
  a_frame_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done |=> bit_cnt == 5'h00) else $error("frame not closed at 32 bits");
  a_enable_set: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && fr.op == OP_SPECIAL && fr.b2 == SUB_ENABLE |=> enabled)
    else $error("enable frame ignored");
  a_echo_byte: assert property (@(posedge clk) disable iff (!reset_n)
    byte_done && bit_cnt[4:3] == 2'h1 |=> out_pend == $past(next_rx[7:0]))
    else $error("second byte not staged for echo");
  a_poll_status: assert property (@(posedge clk) disable iff (!reset_n)
    byte_done && bit_cnt[4:3] == BYTE_IDX_THIRD && hd.op == OP_POLL
    |=> out_pend[0] == $past(operation_pending_flag)) else $error("poll bit wrong");
  a_miso_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !sck_fall |=> $stable(miso)) else $error("output moved off falling edge");
  a_erase_lock: assert property (@(posedge clk) disable iff (!reset_n)
    accept && fr.op == OP_SPECIAL && fr.b2 == SUB_ERASE
    |=> lock_bits == ERASED_BYTE && operation_pending_flag ##1 op == ISP_ERASE)
    else $error("chip erase did not start");
  a_ext_kept: assert property (@(posedge clk) disable iff (!reset_n)
    !(accept && fr.op == OP_LD_EXT) |=> $stable(ext_addr))
    else $error("extended address changed without load");
endmodule

// *** test/isp_host_model.sv ***
// Behavioural model of the external programmer that drives the serial link.
`timescale 1ns/1ps
module isp_host_model (
  input wire logic clk,
  output logic pin_reset_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // Reset pin and link clock start low, so the port opens at power-up.
  initial
  begin
    pin_reset_n = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end

  // Shifts out nb bits of f, MSB first, and samples miso on each rise.
  // Every phase lasts four or five cycles, above the three-cycle floor.
  task automatic xfer(input logic [31:0] f, input int nb, output logic [31:0] r);
    r = 32'h0000_0000;
    for (int i = 31; i > 31 - nb; i--)
    begin
      @(posedge clk);
      mosi <= f[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      r[i] = miso;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
    // The released data line shows the inverse, so a stale bit never looks valid.
    mosi <= ~f[32 - nb];
  endtask

  // Moves the reset pin and lets eight cycles pass for the change to settle.
  task automatic set_pin(input logic v);
    @(posedge clk);
    pin_reset_n <= v;
    repeat (8) @(posedge clk);
  endtask
endmodule

// *** test/isp_serial_prog_test.sv ***
// Self-checking bench for the serial programming port.
`timescale 1ns/1ps
module isp_serial_prog_test;
  import isp_pkg::*;
  // Short busy times keep the run brief; each still covers its array.
  localparam int unsigned FW = 300;
  localparam int unsigned EW = 40;
  localparam int unsigned CW = 600;
  localparam logic [23:0] SIG = 24'hA1B2C3; // Arbitrary identity value.
  localparam logic [7:0] CAL = 8'h5E;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic pin_reset_n, sck, mosi, miso, miso_oe, pend;
  int err_count = 0;
  int n_compared = 0;
  logic [31:0] r; // Bits returned during the last frame.

  isp_serial_prog #(.FLASH_AW(8), .EE_AW(6),
    .FLASH_WAIT_CYC(FW), .EE_WAIT_CYC(EW), .ERASE_WAIT_CYC(CW),
    .SIGNATURE(SIG), .CALIBRATION(CAL)) uut (.clk(clk), .reset_n(reset_n),
    .pin_reset_n(pin_reset_n), .sck(sck), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .operation_pending_flag(pend));

  isp_host_model host (.clk(clk), .pin_reset_n(pin_reset_n), .sck(sck), .mosi(mosi),
    .miso(miso));

  // 40 MHz system clock.
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // Compares one byte; case inequality so an unknown never matches.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Waits, under a bound, for the busy flag to drop; n returns the cycles spent.
  task automatic wait_idle(input int lim, output int n);
    n = 0;
    while (pend === 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > lim)
      begin
        err_count++;
        $display("ERROR %0t busy flag stuck", $time);
        end_of_test();
      end
    end
  endtask

  // One read frame; the answer sits in the fourth byte.
  task automatic rd(input logic [31:0] f, input logic [7:0] e);
    host.xfer(f, 32, r);
    check(r[7:0], e, "read");
  endtask

  // One self-timed write; busy must rise and last close to its full time.
  task automatic wr(input logic [31:0] f, input int lim);
    int n;
    host.xfer(f, 32, r);
    repeat (2) @(posedge clk);
    check({7'h00, pend}, 8'h01, "pending");
    wait_idle(lim, n);
    check({7'h00, n + 20 >= lim}, 8'h01, "busy time");
  endtask

  // Port opens with the pin low, but an erase before enable is ignored.
  task automatic t_locked();
    check({7'h00, miso_oe}, 8'h01, "oe with pin low");
    host.xfer({OP_SPECIAL, SUB_ERASE, 16'h0000}, 32, r);
    repeat (3) @(posedge clk);
    check({7'h00, pend}, 8'h00, "erase before enable");
    $display("t_locked done");
  endtask

  // Enable frame: bytes two and three each echo the byte before them.
  task automatic t_enable();
    host.xfer({OP_SPECIAL, SUB_ENABLE, 16'h0000}, 32, r);
    check(r[23:16], OP_SPECIAL, "first echo");
    check(r[15:8], SUB_ENABLE, "enable echo");
    $display("t_enable done");
  endtask

  // Chip erase, polled while busy and after, then both arrays read back as ones.
  task automatic t_erase();
    int n;
    host.xfer({OP_SPECIAL, SUB_ERASE, 16'h0000}, 32, r);
    host.xfer({OP_POLL, 24'h000000}, 32, r);
    check({7'h00, r[0]}, 8'h01, "poll busy");
    wait_idle(CW, n);
    host.xfer({OP_POLL, 24'h000000}, 32, r);
    check({7'h00, r[0]}, 8'h00, "poll idle");
    rd({OP_RD_PG_LO, 16'h00FF, 8'h00}, ERASED_BYTE);
    rd({OP_RD_PG_HI, 16'h0000, 8'h00}, ERASED_BYTE);
    rd({OP_RD_EE, 16'h003F, 8'h00}, ERASED_BYTE);
    $display("t_erase done");
  endtask

  // Page load of two words, low byte first, written through another word of the page.
  task automatic t_flash();
    host.xfer({OP_LD_EXT, 8'h00, 8'h00, 8'h00}, 32, r);
    host.xfer({OP_LD_PG_LO, 8'h00, 8'h05, 8'hA5}, 32, r);
    host.xfer({OP_LD_PG_HI, 8'h00, 8'h05, 8'h5A}, 32, r);
    host.xfer({OP_LD_PG_LO, 8'h00, 8'h06, 8'h3C}, 32, r);
    host.xfer({OP_LD_PG_HI, 8'h00, 8'h06, 8'hC3}, 32, r);
    wr({OP_WR_PG, 8'h00, 8'h7F, 8'h00}, FW);
    rd({OP_RD_PG_LO, 16'h0005, 8'h00}, 8'hA5);
    rd({OP_RD_PG_HI, 16'h0005, 8'h00}, 8'h5A);
    rd({OP_RD_PG_LO, 16'h0006, 8'h00}, 8'h3C);
    rd({OP_RD_PG_HI, 16'h0006, 8'h00}, 8'hC3);
    $display("t_flash done");
  endtask

  // Byte writes over a written cell need no erase; then one page write.
  task automatic t_eeprom();
    wr({OP_WR_EE, 16'h0003, 8'h3C}, EW);
    rd({OP_RD_EE, 16'h0003, 8'h00}, 8'h3C);
    wr({OP_WR_EE, 16'h0003, 8'hC3}, EW);
    rd({OP_RD_EE, 16'h0003, 8'h00}, 8'hC3);
    host.xfer({OP_LD_EE_PG, 16'h0001, 8'h11}, 32, r);
    wr({OP_WR_EE_PG, 16'h0000, 8'h00}, EW);
    rd({OP_RD_EE, 16'h0001, 8'h00}, 8'h11);
    $display("t_eeprom done");
  endtask

  // Fuses and lock read unprogrammed, then are written and read back; ids too.
  task automatic t_fuses();
    logic [7:0] ws [4] = '{SUB_FUSE_LO, SUB_FUSE_HI, SUB_FUSE_EXT, SUB_LOCK};
    logic [7:0] ro [4] = '{OP_RD_FUSE, OP_RD_LOCK_HF, OP_RD_FUSE, OP_RD_LOCK_HF};
    logic [7:0] rs [4] = '{SUB_NONE, SUB_HIGH_SEL, SUB_HIGH_SEL, SUB_NONE};
    logic [7:0] v [4] = '{8'hE2, 8'hD9, 8'hFD, 8'hFC};
    for (int k = 0; k < 4; k++)
    begin
      rd({ro[k], rs[k], 16'h0000}, ERASED_BYTE);
      wr({OP_SPECIAL, ws[k], 8'h00, v[k]}, FW);
      rd({ro[k], rs[k], 16'h0000}, v[k]);
    end
    for (int k = 0; k < 3; k++)
    begin
      rd({OP_RD_SIG, 8'h00, 8'(k), 8'h00}, SIG[8 * k +: 8]);
    end
    rd({OP_RD_CAL, 24'h000000}, CAL);
    $display("t_fuses done");
  endtask

  // Raising the pin mid-frame closes the port and drops enable until it is resent.
  task automatic t_pin();
    host.xfer({OP_SPECIAL, SUB_ERASE, 16'h0000}, 12, r);
    host.set_pin(1'b1);
    check({7'h00, miso_oe}, 8'h00, "oe with pin high");
    host.set_pin(1'b0);
    host.xfer({OP_SPECIAL, SUB_ERASE, 16'h0000}, 32, r);
    repeat (3) @(posedge clk);
    check({7'h00, pend}, 8'h00, "erase after pin pulse");
    host.xfer({OP_SPECIAL, SUB_ENABLE, 16'h0000}, 32, r);
    check(r[15:8], SUB_ENABLE, "echo after retry");
    $display("t_pin done");
  endtask

  // Main sequence: twelve cycles of reset, then each scenario in turn.
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_locked();
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    t_fuses();
    t_pin();
    end_of_test();
  end
endmodule
